// ---- common/spio_pkg.sv ----
// shared constants for the shared-pin parallel io port
package spio_pkg;

  // bus geometry
  localparam int          SPIO_ADDR_W    = 8;
  localparam int          SPIO_DATA_W    = 32;
  localparam int          SPIO_STRB_W    = SPIO_DATA_W / 8;

  // port geometry defaults
  localparam int          SPIO_PORT_W    = 16;
  localparam logic [31:0] SPIO_IMPL_MASK = 32'h0000_ffff;  // bits that exist on this variant
  localparam logic [31:0] SPIO_OCAP_MASK = 32'h0000_ffff;  // bits whose peripheral can drive out

  // register byte offsets
  localparam logic [SPIO_ADDR_W-1:0] SPIO_DIR_OFS = 8'h00;  // pin_direction_reg
  localparam logic [SPIO_ADDR_W-1:0] SPIO_LAT_OFS = 8'h04;  // output_latch_reg
  localparam logic [SPIO_ADDR_W-1:0] SPIO_LVL_OFS = 8'h08;  // pin_level_reg
  localparam logic [SPIO_ADDR_W-1:0] SPIO_OWN_OFS = 8'h0c;  // peripheral ownership, read only

  // reset values before masking with the implemented bits
  localparam logic [31:0] SPIO_DIR_RST   = 32'hffff_ffff;  // all inputs
  localparam logic [31:0] SPIO_LAT_RST   = 32'h0000_0000;

endpackage : spio_pkg

// ---- src/spio_pin.sv ----
// one pin slice: input synchroniser, output muxes and loop-through block
`timescale 1ns/100ps
module spio_pin #(
  parameter bit IMPL    = 1'b1,
  parameter bit OUT_CAP = 1'b1
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic dir_i,
  input  wire logic lat_i,
  input  wire logic periph_en_i,
  input  wire logic periph_drv_i,
  input  wire logic periph_dout_i,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      level_o,
  output logic      periph_din_o,
  output logic      periph_own_o
);

  logic sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic own_d, dout_d, oe_d, din_d, lvl_out_d;

  // level only moves once the two later stages agree, filtering a single late sample
  always_comb begin
    level_d = (sync2_q == sync3_q) ? sync2_q : level_q;
  end

  // input-only partners never win the pin, so the port keeps full control there
  always_comb begin
    own_d     = IMPL & OUT_CAP & periph_en_i & periph_drv_i;
    dout_d    = own_d ? periph_dout_i : lat_i;
    oe_d      = IMPL & (own_d | ~dir_i);
    din_d     = (IMPL & ~own_d & ~dir_i) ? 1'b0 : level_q;
    lvl_out_d = IMPL & level_q;
  end

  // everything leaving the slice is registered
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_q      <= 1'b0;
      sync2_q      <= 1'b0;
      sync3_q      <= 1'b0;
      level_q      <= 1'b0;
      pin_o        <= 1'b0;
      pin_oe_o     <= 1'b0;
      level_o      <= 1'b0;
      periph_din_o <= 1'b0;
      periph_own_o <= 1'b0;
    end else begin
      sync1_q      <= pin_i;
      sync2_q      <= sync1_q;
      sync3_q      <= sync2_q;
      level_q      <= level_d;
      pin_o        <= dout_d;
      pin_oe_o     <= oe_d;
      level_o      <= lvl_out_d;
      periph_din_o <= din_d;
      periph_own_o <= own_d;
    end
  end

  periph_owns_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (IMPL && OUT_CAP && periph_en_i && periph_drv_i) |=> (pin_oe_o && pin_o == $past(periph_dout_i)))
    else $error("peripheral drive did not take the pin");

  port_drives_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (IMPL && !(OUT_CAP && periph_en_i && periph_drv_i)) |=>
      (pin_oe_o == !$past(dir_i) && (!pin_oe_o || pin_o == $past(lat_i))))
    else $error("port direction or latch not on pin");

  loop_block_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pin_oe_o && !periph_own_o) |-> !periph_din_o)
    else $error("port output looped into peripheral input");

  input_only_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!OUT_CAP || !IMPL) |-> !periph_own_o)
    else $error("input-only partner took the pin");

endmodule : spio_pin

// ---- src/spio_port.sv ----
// shared-pin parallel io port with apb register access
`timescale 1ns/100ps
module spio_port
  import spio_pkg::*;
#(
  parameter int          PORT_W    = SPIO_PORT_W,
  parameter logic [31:0] IMPL_MASK = SPIO_IMPL_MASK,
  parameter logic [31:0] OCAP_MASK = SPIO_OCAP_MASK
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   sys_rst_i,
  // apb slave
  input  wire logic [SPIO_ADDR_W-1:0] paddr_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [SPIO_DATA_W-1:0] pwdata_i,
  input  wire logic [SPIO_STRB_W-1:0] pstrb_i,
  output logic      [SPIO_DATA_W-1:0] prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // peripheral side, one bit per pin
  input  wire logic [PORT_W-1:0]      periph_en_i,
  input  wire logic [PORT_W-1:0]      periph_drv_i,
  input  wire logic [PORT_W-1:0]      periph_dout_i,
  output logic      [PORT_W-1:0]      periph_din_o,
  // device pins
  input  wire logic [PORT_W-1:0]      pin_i,
  output logic      [PORT_W-1:0]      pin_o,
  output logic      [PORT_W-1:0]      pin_oe_o
);

  localparam logic [PORT_W-1:0] IMPL   = IMPL_MASK[PORT_W-1:0];
  localparam logic [PORT_W-1:0] DIR_RV = SPIO_DIR_RST[PORT_W-1:0] & IMPL;
  localparam logic [PORT_W-1:0] LAT_RV = SPIO_LAT_RST[PORT_W-1:0] & IMPL;

  logic [PORT_W-1:0]      dir_q, dir_d;
  logic [PORT_W-1:0]      lat_q, lat_d;
  logic [PORT_W-1:0]      level_w;
  logic [PORT_W-1:0]      own_w;
  logic [PORT_W-1:0]      be_w;
  logic [PORT_W-1:0]      wbits_w;
  logic [SPIO_DATA_W-1:0] prdata_d;
  logic                   pready_d;
  logic                   pslverr_d;
  logic                   setup_w;
  logic                   wr_w;

  // apb phases; the answer is prepared in setup so pready comes from a flop
  assign setup_w = psel_i & ~penable_i;
  assign wr_w    = psel_i & penable_i & pready_o & pwrite_i;

  // byte strobes widened to one enable per port bit
  always_comb begin
    be_w = '0;
    for (int i = 0; i < PORT_W; i++) begin
      be_w[i] = pstrb_i[i/8];
    end
    wbits_w = pwdata_i[PORT_W-1:0];
  end

  // register next values: writes land only in the access cycle with pready high
  always_comb begin
    dir_d = dir_q;
    lat_d = lat_q;
    if (wr_w) begin
      if (paddr_i == SPIO_DIR_OFS) begin
        dir_d = ((dir_q & ~be_w) | (wbits_w & be_w)) & IMPL;
      end else if (paddr_i == SPIO_LAT_OFS) begin
        lat_d = ((lat_q & ~be_w) | (wbits_w & be_w)) & IMPL;
      end else if (paddr_i == SPIO_LVL_OFS) begin
        lat_d = ((lat_q & ~be_w) | (wbits_w & be_w)) & IMPL;
      end
    end
  end

  // read mux and response; unmapped offsets answer with an error and zero data
  always_comb begin
    prdata_d  = '0;
    pready_d  = setup_w;
    pslverr_d = 1'b0;
    if (setup_w) begin
      if (paddr_i == SPIO_DIR_OFS) begin
        prdata_d[PORT_W-1:0] = dir_q & IMPL;
      end else if (paddr_i == SPIO_LAT_OFS) begin
        prdata_d[PORT_W-1:0] = lat_q & IMPL;
      end else if (paddr_i == SPIO_LVL_OFS) begin
        prdata_d[PORT_W-1:0] = level_w & IMPL;
      end else if (paddr_i == SPIO_OWN_OFS) begin
        prdata_d[PORT_W-1:0] = own_w;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // register state and bus outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dir_q     <= DIR_RV;
      lat_q     <= LAT_RV;
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      dir_q     <= dir_d;
      lat_q     <= lat_d;
      prdata_o  <= prdata_d;
      pready_o  <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end

  // one slice per pin; unimplemented slices tie everything low except periph_din_o, which still follows the pin
  for (genvar g = 0; g < PORT_W; g++) begin : g_pin
    spio_pin #(
      .IMPL    (IMPL_MASK[g]),
      .OUT_CAP (OCAP_MASK[g])
    ) u_pin (
      .core_clk_i    (core_clk_i),
      .sys_rst_i     (sys_rst_i),
      .dir_i         (dir_q[g]),
      .lat_i         (lat_q[g]),
      .periph_en_i   (periph_en_i[g]),
      .periph_drv_i  (periph_drv_i[g]),
      .periph_dout_i (periph_dout_i[g]),
      .pin_i         (pin_i[g]),
      .pin_o         (pin_o[g]),
      .pin_oe_o      (pin_oe_o[g]),
      .level_o       (level_w[g]),
      .periph_din_o  (periph_din_o[g]),
      .periph_own_o  (own_w[g])
    );
  end

  dir_reset_a: assert property (
    @(posedge core_clk_i) $past(sys_rst_i) |-> (dir_q == DIR_RV && pin_oe_o == '0))
    else $error("pins not inputs after reset");

  lat_write_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_w && paddr_i == SPIO_LAT_OFS && &pstrb_i) |=> lat_q == ($past(pwdata_i[PORT_W-1:0]) & IMPL))
    else $error("latch write lost");

  lvl_write_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_w && paddr_i == SPIO_LVL_OFS && &pstrb_i) |=> (lat_q == ($past(pwdata_i[PORT_W-1:0]) & IMPL)
      && $stable(dir_q)))
    else $error("level write not redirected to latch");

  lvl_read_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && !pwrite_i && paddr_i == SPIO_LVL_OFS) |=> prdata_o[PORT_W-1:0] == $past(level_w))
    else $error("level read not pin state");

  unimpl_zero_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ((dir_q & ~IMPL) == '0) && ((lat_q & ~IMPL) == '0) && ((level_w & ~IMPL) == '0))
    else $error("unimplemented bit not zero");

  apb_ready_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    setup_w |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle after setup");

  unmapped_err_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && paddr_i > SPIO_OWN_OFS) |=> (pslverr_o && prdata_o == '0))
    else $error("unmapped access without error");

  // expected pin ownership, rebuilt from the block inputs for the checks below
  logic [PORT_W-1:0] own_in_w;
  assign own_in_w = periph_en_i & periph_drv_i & OCAP_MASK[PORT_W-1:0] & IMPL;

  // read data stands only in the answer cycle, so a stray capture sees zero
  rd_idle_zero_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !pready_o |-> prdata_o == '0)
    else $error("read data outside the answer cycle");

  // an error answer carries no data
  err_no_data_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pslverr_o |-> prdata_o == '0)
    else $error("error answer with data");

  // bits above the port width never carry data
  rd_high_zero_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (prdata_o >> PORT_W) == '0)
    else $error("read data above port width");

  // an error is only reported together with the answer
  err_with_ready_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pslverr_o |-> pready_o)
    else $error("error without ready");

  // the answer only appears while the master is in its access phase
  ready_in_access_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pready_o |-> (psel_i && penable_i))
    else $error("ready outside an access phase");

  // mapped, aligned offsets never answer with an error
  mapped_no_err_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && paddr_i <= SPIO_OWN_OFS && paddr_i[1:0] == 2'b00) |=> !pslverr_o)
    else $error("mapped access answered with error");

  // direction reads return the stored bits
  rd_dir_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && paddr_i == SPIO_DIR_OFS) |=> prdata_o[PORT_W-1:0] == $past(dir_q))
    else $error("direction read wrong");

  // latch reads return the latch, not the pins
  rd_lat_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && paddr_i == SPIO_LAT_OFS) |=> prdata_o[PORT_W-1:0] == $past(lat_q))
    else $error("latch read wrong");

  // ownership reads mirror the per-pin owner flags
  rd_own_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (setup_w && paddr_i == SPIO_OWN_OFS) |=> prdata_o[PORT_W-1:0] == $past(own_w))
    else $error("ownership read wrong");

  // a full direction write lands and leaves the latch alone
  dir_write_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_w && paddr_i == SPIO_DIR_OFS && &pstrb_i) |=>
      (dir_q == ($past(pwdata_i[PORT_W-1:0]) & IMPL) && $stable(lat_q)))
    else $error("direction write lost");

  // strobed-off bytes of the latch keep their old value
  strobe_keep_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_w && paddr_i == SPIO_LAT_OFS) |=> ((lat_q ^ $past(lat_q)) & ~$past(be_w)) == '0)
    else $error("strobed-off latch bits changed");

  // the ownership register and unmapped offsets take no writes
  own_read_only_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_w && paddr_i >= SPIO_OWN_OFS) |=> ($stable(dir_q) && $stable(lat_q)))
    else $error("read-only or unmapped write took effect");

  // without a write cycle the registers hold
  regs_hold_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !wr_w) |=> ($stable(dir_q) && $stable(lat_q)))
    else $error("register changed without a write");

  // the owner flag follows enable, drive and the output-capable mask
  own_mux_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> own_w == $past(own_in_w))
    else $error("pin owner flag wrong");

  // output enable: peripheral first, then the direction bit
  oe_mux_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> pin_oe_o == (IMPL & ($past(own_in_w) | ~$past(dir_q))))
    else $error("pin output enable wrong");

  // output data: peripheral first, then the latch
  dout_mux_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=>
      pin_o == (($past(own_in_w) & $past(periph_dout_i)) | (~$past(own_in_w) & $past(lat_q))))
    else $error("pin output data wrong");

  // a port-driven pin never reaches the peripheral input
  loop_din_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> (periph_din_o & IMPL & ~$past(own_in_w) & ~$past(dir_q)) == '0)
    else $error("port output reached peripheral input");

  // an owning peripheral still sees the same level that software reads
  din_sees_pin_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ((periph_din_o ^ level_w) & own_w) == '0)
    else $error("owning peripheral does not see the pin");

  // unimplemented bits never drive their pin
  unimpl_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ((pin_oe_o & ~IMPL) == '0) && ((pin_o & ~IMPL) == '0))
    else $error("unimplemented bit drives its pin");

  // reset also clears the latch and lets go of every pin and peripheral input
  rst_latch_a: assert property (
    @(posedge core_clk_i)
    sys_rst_i |=> (lat_q == LAT_RV && pin_o == '0 && periph_din_o == '0))
    else $error("latch or pin outputs not cleared by reset");

endmodule : spio_port

// ---- tb/spio_pin_model.sv ----
// far-side pin model: outside drivers meet the port's output buffers
`timescale 1ns/100ps
module spio_pin_model #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pin_i_o
);
  // a driven pin shows its buffer, an undriven one the outside level
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule : spio_pin_model

// ---- tb/spio_port_tb.sv ----
// self-checking bench for the shared-pin io port
`timescale 1ns/100ps
module spio_port_tb
  import spio_pkg::*;
;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic        er;
  } spio_row_type;

  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic [7:0]  paddr      = 8'h00;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  pstrb      = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] en         = 16'h0;
  logic [15:0] drv        = 16'h0;
  logic [15:0] dout       = 16'h0;
  logic [15:0] ext        = 16'h0;
  logic [15:0] din;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [31:0] rd;
  logic        er;
  int          n_fail     = 0;
  int          compares   = 0;
  // bit 15 absent, bit 0 has an input-only partner
  spio_row_type rows [6] = '{
    '{SPIO_DIR_OFS, 32'hffff_0000, 4'hf, SPIO_DIR_OFS, 32'h0000_0000, 1'b0},
    '{SPIO_LAT_OFS, 32'hffff_a5a5, 4'hf, SPIO_LAT_OFS, 32'h0000_25a5, 1'b0},
    '{SPIO_LVL_OFS, 32'h0000_5a5a, 4'hf, SPIO_LAT_OFS, 32'h0000_5a5a, 1'b0},
    '{SPIO_LAT_OFS, 32'h0000_ffff, 4'h1, SPIO_LAT_OFS, 32'h0000_5aff, 1'b0},
    '{SPIO_OWN_OFS, 32'h0000_ffff, 4'hf, SPIO_OWN_OFS, 32'h0000_0000, 1'b0},
    '{8'h10,        32'h0000_ffff, 4'hf, 8'h10,        32'h0000_0000, 1'b1}};

  // free-running system clock
  always #5 core_clk_i = ~core_clk_i;

  spio_port #(.PORT_W(16), .IMPL_MASK(32'h0000_7fff), .OCAP_MASK(32'h0000_fffe)) uut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .periph_en_i(en),
    .periph_drv_i(drv), .periph_dout_i(dout), .periph_din_o(din), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_o(pin_oe));

  spio_pin_model #(.W(16)) pins (.pin_o_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext), .pin_i_o(pin_in));

  task stop_test;
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; a missing pready ends the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] r, output logic e);
    int i;
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // settle time covers the pin synchronisers
  task settle;
    repeat (8) @(posedge core_clk_i);
  endtask : settle

  initial begin
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[k]) begin
      apb(1'b1, rows[k].wa, rows[k].wd, rows[k].ws, rd, er);
      apb(1'b0, rows[k].ra, 32'h0, 4'h0, rd, er);
      chk(rd, rows[k].rd);
      chk({31'h0, er}, {31'h0, rows[k].er});
    end
    // all implemented pins are port outputs now
    settle();
    chk({16'h0, pin_oe}, 32'h0000_7fff);
    chk({16'h0, pin_out}, 32'h0000_5aff);
    chk({16'h0, din}, 32'h0);
    apb(1'b0, SPIO_LVL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_5aff);
    // bits 7:4 taken by the peripheral, bit 0 stays with the port
    en   <= 16'hffff;
    drv  <= 16'h00f1;
    dout <= 16'h0011;
    settle();
    chk({16'h0, pin_oe}, 32'h0000_7fff);
    chk({16'h0, pin_out}, 32'h0000_5a1f);
    chk({16'h0, din}, 32'h0000_0010);
    apb(1'b0, SPIO_OWN_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_00f0);
    apb(1'b0, SPIO_LVL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_5a1f);
    // every pin an input, outside drives even the absent bit
    en  <= 16'h0;
    drv <= 16'h0;
    ext <= 16'hbc96;
    apb(1'b1, SPIO_DIR_OFS, 32'h0000_ffff, 4'hf, rd, er);
    settle();
    chk({16'h0, pin_oe}, 32'h0);
    apb(1'b0, SPIO_LVL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_3c96);
    // reset in mid-run while pins are outputs
    apb(1'b1, SPIO_DIR_OFS, 32'h0, 4'hf, rd, er);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk({16'h0, pin_oe}, 32'h0);
    chk({16'h0, pin_out}, 32'h0);
    apb(1'b0, SPIO_DIR_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_7fff);
    apb(1'b0, SPIO_LAT_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : spio_port_tb
